// ===== design/mim_pkg.sv
/*
 * Constants for the MAC interrupt mask and PHY management block:
 * register offsets, field positions, reset values and cycle counts.
 * Assumes a 200 MHz APB clock.
 */
package mim_pkg;
   // -------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_IRQ_EN = 8'h28;
   localparam logic [7:0] OFS_IRQ_DIS = 8'h2C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
   localparam logic [7:0] OFS_PHY_MAN = 8'h34;
   localparam logic [7:0] OFS_PAUSE = 8'h38;
   // -------------------------------------------------------------
   // interrupt source bits
   // -------------------------------------------------------------
   localparam int EVT_W = 14;
   localparam int BIT_MGMT_DONE = 0;
   localparam int BIT_PAUSE_ZERO = 13;
   localparam logic [13:0] EVT_VALID = 14'h3CFF;
   localparam logic [13:0] MASK_RST = 14'h3CFF;
   // -------------------------------------------------------------
   // management frame fields
   // -------------------------------------------------------------
   localparam int MAN_DATA_W = 16;
   localparam int MAN_CODE_LSB = 16;
   localparam int MAN_OP_LSB = 28;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [31:0] MAN_RST = 32'h0;
   localparam logic [5:0] POS_PRE_END = 6'h1F;
   localparam logic [5:0] POS_TA = 6'h2E;
   localparam logic [5:0] POS_RDATA = 6'h30;
   localparam logic [5:0] POS_LAST = 6'h3F;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_NS = 5;
   localparam int MDC_PERIOD_NS = 400;
   localparam int MDC_HALF_CYC = MDC_PERIOD_NS / 2 / CLK_NS;
   localparam int BIT_TIME_NS = 10;
   localparam int PAUSE_QUANTUM_NS = 512 * BIT_TIME_NS;
   localparam int PAUSE_CYC = PAUSE_QUANTUM_NS / CLK_NS;
   localparam logic [15:0] PAUSE_RST = 16'h0;
endpackage

// ===== design/mim_top.sv
/*
 * MAC interrupt enable/disable/mask control, sticky event status,
 * PHY management frame shifter and pause time countdown, on APB.
 * Assumes event inputs are one-cycle pulses synchronous to mclk_i
 * and an external pull-up on the management data wire.
 */
//
// Behaviour
// - enable register bit 0 unmasks management-done interrupt
// - receive event enables at bits 1, 2 and 10
// - transmit event enables at bits 3 to 7
// - bus error bit 11, pause frame bit 12, pause zero bit 13
// - disable register uses same bits and masks each source
// - mask register reports the mask state of all twelve sources
// - after a management read the data field holds the PHY value
// - turnaround code is written 10 and reads back as written
// - operation 10 is read, 01 is write, others invalid
// - management done sets a status flag cleared by status read
// - 16-bit pause time decrements every 512 bit times, zero event
`timescale 1ns/10ps
module mim_top (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic rx_frame_stored_irq_i,
   input wire logic rx_desc_used_irq_i,
   input wire logic tx_desc_used_irq_i,
   input wire logic tx_underrun_irq_i,
   input wire logic retry_limit_irq_i,
   input wire logic tx_buffers_exhausted_irq_i,
   input wire logic tx_frame_sent_irq_i,
   input wire logic rx_overrun_irq_i,
   input wire logic bus_error_irq_i,
   input wire logic pause_frame_rx_irq_i,
   output logic irq_o,
   output logic mdc_o,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic mdio_i
);
   typedef enum logic [2:0] {
      MIM_IDLE = 3'b001,
      MIM_PRE = 3'b010,
      MIM_SHIFT = 3'b100
   } mim_state_e;

   // -------------------------------------------------------------
   // apb slave
   // -------------------------------------------------------------
   logic pready_ff, pslverr_ff;
   logic [31:0] prdata_ff, rd_val;
   logic hit, acc, first;
   logic [13:0] status_ff, mask_ff, evt, rd_clr;
   logic [31:0] man_ff;
   logic [15:0] pause_ff;
   logic busy;

   assign first = psel_i & penable_i & ~pready_ff;
   assign acc = psel_i & penable_i & pready_ff;

   always_comb begin
      hit = 1'b1;
      rd_val = 32'h0;
      unique case (paddr_i)
         mim_pkg::OFS_STATUS: rd_val = {18'h0, status_ff};
         mim_pkg::OFS_IRQ_EN: rd_val = 32'h0;
         mim_pkg::OFS_IRQ_DIS: rd_val = 32'h0;
         mim_pkg::OFS_IRQ_MASK: rd_val = {18'h0, mask_ff};
         mim_pkg::OFS_PHY_MAN: rd_val = man_ff;
         mim_pkg::OFS_PAUSE: rd_val = {16'h0, pause_ff};
         default: hit = 1'b0;
      endcase
   end

   // one wait state: ready comes the cycle after the first access cycle
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else begin
         pready_ff <= first;
         if (first) begin
            pslverr_ff <= ~hit;
            prdata_ff <= pwrite_i ? 32'h0 : rd_val;
         end
      end
   end

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;

   logic wr_en, wr_dis, wr_man, wr_pause, rd_stat;
   assign wr_en = acc & pwrite_i & (paddr_i == mim_pkg::OFS_IRQ_EN);
   assign wr_dis = acc & pwrite_i & (paddr_i == mim_pkg::OFS_IRQ_DIS);
   assign wr_man = acc & pwrite_i & (paddr_i == mim_pkg::OFS_PHY_MAN);
   assign wr_pause = acc & pwrite_i & (paddr_i == mim_pkg::OFS_PAUSE);
   assign rd_stat = acc & ~pwrite_i & (paddr_i == mim_pkg::OFS_STATUS);

   // -------------------------------------------------------------
   // event status and mask
   // -------------------------------------------------------------
   logic mgmt_done_irq, pause_zero_irq;
   assign evt = {pause_zero_irq, pause_frame_rx_irq_i, bus_error_irq_i,
                 rx_overrun_irq_i, 2'b00, tx_frame_sent_irq_i,
                 tx_buffers_exhausted_irq_i, retry_limit_irq_i,
                 tx_underrun_irq_i, tx_desc_used_irq_i,
                 rx_desc_used_irq_i, rx_frame_stored_irq_i,
                 mgmt_done_irq};
   // only bits the reader actually saw are cleared, so an event in the
   // wait state or at the clearing edge survives
   assign rd_clr = rd_stat ? prdata_ff[13:0] : 14'h0;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_ff <= 14'h0;
      end else begin
         status_ff <= (status_ff & ~rd_clr) | evt;
      end
   end

   // mask bit high means the source is masked; all start masked
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mask_ff <= mim_pkg::MASK_RST;
      end else if (wr_en) begin
         mask_ff <= mask_ff & ~(pwdata_i[13:0] & mim_pkg::EVT_VALID);
      end else if (wr_dis) begin
         mask_ff <= mask_ff | (pwdata_i[13:0] & mim_pkg::EVT_VALID);
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_ff & ~mask_ff);
      end
   end

   // -------------------------------------------------------------
   // pause time countdown
   // -------------------------------------------------------------
   logic [10:0] pq_ff;
   logic pq_tick;
   assign pq_tick = (pq_ff == 11'(mim_pkg::PAUSE_CYC - 1));

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pq_ff <= 11'h0;
         pause_ff <= mim_pkg::PAUSE_RST;
      end else if (wr_pause) begin
         pq_ff <= 11'h0;
         pause_ff <= pwdata_i[15:0];
      end else begin
         pq_ff <= pq_tick ? 11'h0 : pq_ff + 11'h1;
         if (pq_tick && pause_ff != 16'h0) begin
            pause_ff <= pause_ff - 16'h1;
         end
      end
   end

   assign pause_zero_irq = pq_tick & (pause_ff == 16'h1) & ~wr_pause;

   // -------------------------------------------------------------
   // management frame shifter: 32 preamble ones then the frame
   // -------------------------------------------------------------
   mim_state_e st_ff;
   logic [5:0] pos_ff, div_ff;
   logic [15:0] rsh_ff;
   logic is_rd, div_wrap, mdc_fall, mdc_rise, last_bit;
   assign busy = (st_ff != MIM_IDLE);
   assign is_rd = (man_ff[29:28] == mim_pkg::OP_READ);
   assign div_wrap = (div_ff == 6'(mim_pkg::MDC_HALF_CYC - 1));
   assign mdc_fall = busy & div_wrap & mdc_o;
   assign mdc_rise = busy & div_wrap & ~mdc_o;
   assign last_bit = (pos_ff == mim_pkg::POS_LAST);
   assign mgmt_done_irq = mdc_fall & last_bit;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_ff <= MIM_IDLE;
         pos_ff <= 6'h0;
         div_ff <= 6'h0;
         mdc_o <= 1'b0;
      end else begin
         unique case (st_ff)
            MIM_IDLE: begin
               div_ff <= 6'h0;
               mdc_o <= 1'b0;
               pos_ff <= 6'h0;
               if (wr_man) begin
                  st_ff <= MIM_PRE;
               end
            end
            MIM_PRE, MIM_SHIFT: begin
               div_ff <= div_wrap ? 6'h0 : div_ff + 6'h1;
               if (div_wrap) begin
                  mdc_o <= ~mdc_o;
               end
               if (mdc_fall) begin
                  pos_ff <= pos_ff + 6'h1;
                  if (last_bit) begin
                     st_ff <= MIM_IDLE;
                  end else if (pos_ff == mim_pkg::POS_PRE_END) begin
                     st_ff <= MIM_SHIFT;
                  end
               end
            end
         endcase
      end
   end

   // drive the bit for the position being entered at the falling edge
   logic [5:0] npos;
   logic nxt_oe;
   assign npos = mdc_fall ? pos_ff + 6'h1 : pos_ff;
   assign nxt_oe = ~(is_rd && npos >= mim_pkg::POS_TA);

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mdio_o <= 1'b1;
         mdio_oe_o <= 1'b0;
      end else if (wr_man && !busy) begin
         mdio_o <= 1'b1;
         mdio_oe_o <= 1'b1;
      end else if (mdc_fall) begin
         mdio_oe_o <= ~last_bit & nxt_oe;
         mdio_o <= npos[5] ? man_ff[~npos[4:0]] : 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rsh_ff <= 16'h0;
      end else if (mdc_rise && is_rd && pos_ff >= mim_pkg::POS_RDATA) begin
         rsh_ff <= {rsh_ff[14:0], mdio_i};
      end
   end

   // a write while a frame is in flight is dropped whole
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         man_ff <= mim_pkg::MAN_RST;
      end else if (wr_man && !busy) begin
         man_ff <= pwdata_i;
      end else if (mgmt_done_irq && is_rd) begin
         man_ff[15:0] <= rsh_ff;
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   en_unmask_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_en |=> (mask_ff & $past(pwdata_i[13:0]) & mim_pkg::EVT_VALID)
                == 14'h0) else $error("enable write left a bit masked");
   dis_mask_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr_dis |=> mask_ff == ($past(mask_ff) |
         ($past(pwdata_i[13:0]) & mim_pkg::EVT_VALID)))
      else $error("disable write wrong mask");
   mask_read_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (first && !pwrite_i && paddr_i == mim_pkg::OFS_IRQ_MASK)
      |=> prdata_o[13:0] == $past(mask_ff))
      else $error("mask read mismatch");
   mgmt_flag_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      mgmt_done_irq |=> status_ff[mim_pkg::BIT_MGMT_DONE] && !busy)
      else $error("management done flag not set");
   busy_drop_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (wr_man && busy && !mgmt_done_irq) |=> $stable(man_ff))
      else $error("frame register changed while busy");
   code_back_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (wr_man && !busy) |=> ##1 man_ff[17:16] == $past(pwdata_i[17:16], 2))
      else $error("code field not kept");
   pause_zero_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      pause_zero_irq |=> pause_ff == 16'h0 &&
         status_ff[mim_pkg::BIT_PAUSE_ZERO])
      else $error("pause zero event wrong");
   rd_release_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (busy && is_rd && pos_ff >= mim_pkg::POS_TA && !mdc_fall)
      |-> !mdio_oe_o) else $error("driving during read data");
   irq_gate_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      ##1 irq_o == |($past(status_ff) & ~$past(mask_ff)))
      else $error("interrupt output not gated by mask");
   frame_len_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (wr_man && !busy) |=> busy [*8])
      else $error("frame ended too soon");
endmodule

// ===== dv/mim_phy_model.sv
/*
 * Behavioural PHY on the management link: captures every frame and
 * answers read frames with a value derived from PHY and register.
 * Assumes whole 64-bit frames and a pulled-up, resolved data wire.
 */
`timescale 1ns/10ps
module mim_phy_model (
   input wire logic mdc_i,
   input wire logic resetn_i,
   input wire logic mdio_i,
   output logic phy_oe_o,
   output logic phy_d_o,
   output logic [31:0] last_frame_o,
   output logic [7:0] frames_o
);
   logic [5:0] cnt;
   logic [31:0] sr;
   logic [13:0] hdr;
   logic [15:0] rdata;
   logic is_read;
   // -------------------------------------------------------------
   // frame capture
   // -------------------------------------------------------------
   assign is_read = (hdr[11:10] === 2'h2);
   assign rdata = {hdr[9:5], hdr[4:0], 6'h2A};
   always_ff @(posedge mdc_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= 6'h0;
         sr <= 32'h0;
         hdr <= 14'h0;
         last_frame_o <= 32'h0;
         frames_o <= 8'h0;
      end else begin
         cnt <= cnt + 6'h1;
         sr <= {sr[30:0], mdio_i};
         if (cnt == 6'h2D) hdr <= {sr[12:0], mdio_i};
         if (cnt == 6'h3F) begin
            last_frame_o <= {sr[30:0], mdio_i};
            frames_o <= frames_o + 8'h1;
         end
      end
   end
   // -------------------------------------------------------------
   // answer, changed after the clock falls
   // -------------------------------------------------------------
   // released data output shows the inverse so a stale value cannot pass
   always_ff @(negedge mdc_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phy_oe_o <= 1'b0;
         phy_d_o <= 1'b0;
      end else if (is_read && cnt == 6'h2F) begin
         phy_oe_o <= 1'b1;
         phy_d_o <= 1'b0;
      end else if (is_read && cnt >= 6'h30) begin
         phy_oe_o <= 1'b1;
         phy_d_o <= rdata[4'(6'h3F - cnt)];
      end else begin
         phy_oe_o <= 1'b0;
         phy_d_o <= ~phy_d_o;
      end
   end
endmodule

// ===== dv/mim_top_tb_top.sv
/*
 * Self-checking bench for the interrupt mask and management block.
 * Assumes the APB timing, offsets and reset values of mim_pkg.
 */
`timescale 1ns/10ps
module mim_top_tb_top;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;
      logic [31:0] x; logic e;} mim_row_s;
   logic mclk_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata_o, rd, fr;
   logic pready_o, pslverr_o, irq_o, mdc_o, mdio_o, mdio_oe_o, er;
   logic phy_oe, phy_d, mdio_w;
   logic [9:0] ev = 10'h0;
   logic [31:0] last_frame;
   logic [7:0] frames;
   int miscompares = 0, comparisons = 0;
   int evbit[10] = '{1, 2, 3, 4, 5, 6, 7, 10, 11, 12};
   mim_row_s rows[12] = '{
      '{0, 8'h30, 0, 32'h3CFF, 0}, '{0, 8'h24, 0, 0, 0},
      '{0, 8'h38, 0, 0, 0}, '{1, 8'h28, 32'h3CFF, 0, 0},
      '{0, 8'h30, 0, 0, 0}, '{1, 8'h2C, 32'h0401, 0, 0},
      '{0, 8'h30, 0, 32'h0401, 0}, '{1, 8'h2C, 0, 0, 0},
      '{0, 8'h30, 0, 32'h0401, 0}, '{0, 8'h40, 0, 0, 1},
      '{1, 8'h28, 32'h3BFE, 0, 0}, '{0, 8'h30, 0, 32'h0401, 0}};
   assign mdio_w = mdio_oe_o ? mdio_o : (phy_oe ? phy_d : 1'b1);
   mim_top u_mim_top (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o),
      .rx_frame_stored_irq_i(ev[0]), .rx_desc_used_irq_i(ev[1]),
      .tx_desc_used_irq_i(ev[2]), .tx_underrun_irq_i(ev[3]),
      .retry_limit_irq_i(ev[4]), .tx_buffers_exhausted_irq_i(ev[5]),
      .tx_frame_sent_irq_i(ev[6]), .rx_overrun_irq_i(ev[7]),
      .bus_error_irq_i(ev[8]), .pause_frame_rx_irq_i(ev[9]),
      .irq_o(irq_o), .mdc_o(mdc_o), .mdio_o(mdio_o),
      .mdio_oe_o(mdio_oe_o), .mdio_i(mdio_w));
   mim_phy_model u_mim_phy_model (.mdc_i(mdc_o), .resetn_i(resetn_i),
      .mdio_i(mdio_w), .phy_oe_o(phy_oe), .phy_d_o(phy_d),
      .last_frame_o(last_frame), .frames_o(frames));
   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   task automatic chk(input string nm, input logic [31:0] s, x);
      comparisons++;
      if (s !== x) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge mclk_i);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1;
      // no wait count here: only the watchdog may end a stuck transfer
      do begin
         @(posedge mclk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic mgmt(input logic [31:0] f);
      apb(1, 8'h34, f);
      apb(1, 8'h34, 32'h6AAA5555);
      apb(0, 8'h34, 0);
      chk("frame busy", rd, f);
      do begin
         apb(0, 8'h24, 0);
      end while (rd[0] !== 1'b1);
      chk("done flag", rd, 32'h1);
      apb(0, 8'h24, 0);
      chk("done cleared", rd, 32'h0);
   endtask
   task automatic results();
      $display("mismatches %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge mclk_i);
      miscompares++;
      results();
   end
   // -------------------------------------------------------------
   // sequence
   // -------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk_i);
      resetn_i <= 1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("row read", rd, rows[i].x);
         chk("row error", {31'h0, er}, {31'h0, rows[i].e});
      end
      apb(1, 8'h28, 32'h3CFF);
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk_i) ev <= 10'(1 << i);
         @(posedge mclk_i) ev <= 10'h0;
         repeat (2) @(posedge mclk_i);
         #1 chk("irq raised", {31'h0, irq_o}, 32'h1);
         apb(0, 8'h24, 0);
         chk("event status", rd, 32'h1 << evbit[i]);
         repeat (2) @(posedge mclk_i);
         #1 chk("irq dropped", {31'h0, irq_o}, 32'h0);
      end
      apb(1, 8'h2C, 32'h1000);
      @(posedge mclk_i) ev <= 10'h200;
      @(posedge mclk_i) ev <= 10'h0;
      repeat (3) @(posedge mclk_i);
      #1 chk("masked irq", {31'h0, irq_o}, 32'h0);
      apb(0, 8'h24, 0);
      chk("masked status", rd, 32'h1000);
      apb(1, 8'h38, 32'h2);
      repeat (1000) @(posedge mclk_i);
      apb(0, 8'h38, 0);
      chk("pause early", rd, 32'h2);
      repeat (30) @(posedge mclk_i);
      apb(0, 8'h38, 0);
      chk("pause step", rd, 32'h1);
      repeat (1030) @(posedge mclk_i);
      #1 chk("pause irq", {31'h0, irq_o}, 32'h1);
      apb(0, 8'h24, 0);
      chk("pause zero", rd, 32'h2000);
      fr = {2'h1, 2'h1, 5'h03, 5'h04, 2'h2, 16'hA5C3};
      mgmt(fr);
      chk("phy write frame", last_frame, fr);
      chk("frame count", {24'h0, frames}, 32'h1);
      fr = {2'h1, 2'h2, 5'h07, 5'h02, 2'h2, 16'h0};
      mgmt(fr);
      apb(0, 8'h34, 0);
      chk("read data", rd, {fr[31:16], 5'h07, 5'h02, 6'h2A});
      #1 chk("mdc idle", {31'h0, mdc_o}, 32'h0);
      @(posedge mclk_i) resetn_i <= 0;
      repeat (3) @(posedge mclk_i);
      resetn_i <= 1;
      apb(0, 8'h30, 0);
      chk("mask after reset", rd, 32'h3CFF);
      results();
   end
endmodule
